// [logic/gmrs_cfg.svh]
// Constants for the output mux, strap and reset glue
`ifndef GMRS_CFG_SVH
`define GMRS_CFG_SVH
// ==========================================
// Configuration bit positions
`define GMRS_GCFG_CLK_CS_BIT 29
`define GMRS_GCFG_CLK_ALE_BIT 30
`define GMRS_GCFG_KBC_CS_BIT 31
`define GMRS_XBUS_APIC_BIT 8
// ==========================================
// Reset values and the speaker enable bit position
`define GMRS_GCFG_RST 32'he0000000
`define GMRS_XBUS_RST 16'h0000
`define GMRS_GPO_RST 7'h00
`define GMRS_SPEAKER_OUT_EN_BIT 1
`endif

// [logic/gmrs_pkg.sv]
// Types for the output mux, strap and reset glue
package gmrs_pkg;
  // Native functions that may take over the upper general outputs
  typedef struct packed {
    logic clock_chip_select_n;
    logic clock_chip_addr_latch;
    logic keyboard_ctrl_select_n;
    logic apic_int9_out_n;
  } gmrs_native_t;
  // Reset sequencing
  typedef enum logic [1:0] {GMRS_IN_RESET, GMRS_RUN} gmrs_rst_state_t;
endpackage

// [logic/gmrs_sync.sv]
// Two-flop synchroniser for the power-good input
`timescale 1ns/1ps
module gmrs_sync (
  input wire logic clk,
  input wire logic din,
  output logic dout
);
  logic stage1_ff;
  logic stage2_ff;
  // ==========================================
  // No reset: power-good itself is what resets the core
  always_ff @(posedge clk) begin
    stage1_ff <= din;
    stage2_ff <= stage1_ff;
  end
  assign dout = stage2_ff;
endmodule

// [logic/gmrs_top.sv]
// Upper output pin mux, straps, reset generation and speaker gating
`timescale 1ns/1ps
`include "gmrs_cfg.svh"
module gmrs_top (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic POWER_GOOD,
  input wire logic CPU_TYPE_STRAP,
  input wire logic BOOT_DECODE_STRAP,
  input wire logic [31:0] GENERAL_CONFIG_WDATA,
  input wire logic GENERAL_CONFIG_WE,
  input wire logic [15:0] XBUS_CONTROL_WDATA,
  input wire logic XBUS_CONTROL_WE,
  input wire logic [6:0] GENERAL_OUT_WDATA,
  input wire logic GENERAL_OUT_WE,
  input wire logic [7:0] PORT61_WDATA,
  input wire logic PORT61_WE,
  input wire gmrs_pkg::gmrs_native_t NATIVE_IN,
  input wire logic CPU_INIT_REQ,
  input wire logic COUNTER2_OUT,
  input wire logic POWER_ON_SUSPEND,
  input wire logic TOP64K_HIT,
  output logic GENERAL_OUT_24,
  output logic GENERAL_OUT_25,
  output logic GENERAL_OUT_26,
  output logic [1:0] GENERAL_OUT_27_28,
  output logic GENERAL_OUT_29,
  output logic GENERAL_OUT_30,
  output logic CPU_RESET_OUT,
  output logic CPU_INIT_OUT,
  output logic PCI_RESET_OUT_N,
  output logic ISA_RESET_DRIVE,
  output logic SPEAKER_OUT,
  output logic TOP64K_POSITIVE_CLAIM,
  output logic TOP64K_SUBTRACTIVE_CLAIM,
  output logic [31:0] GENERAL_CONFIG_RDATA,
  output logic [15:0] XBUS_CONTROL_RDATA
);
  logic pg_sync;
  logic core_rst;
  logic [31:0] general_config_reg_ff;
  logic [15:0] xbus_control_reg_ff;
  logic [6:0] gpo_ff;
  logic speaker_out_en_ff;
  logic speaker_out_ff;
  logic cpu_type_ff;
  logic boot_decode_ff;
  gmrs_pkg::gmrs_rst_state_t state_ff;
  gmrs_pkg::gmrs_rst_state_t nxt_state;
  logic [6:0] pin_ff;
  logic [6:0] nxt_pin;
  logic cpu_rst_ff;
  logic cpu_init_ff;
  logic pci_rst_n_ff;
  logic isa_rst_ff;
  logic pos_claim_ff;
  logic sub_claim_ff;
  logic in_reset;
  logic nxt_speaker_out;
  logic sel_clk_cs;
  logic sel_clk_ale;
  logic sel_kbc_cs;
  logic sel_apic;
  logic nxt_cpu_rst;
  logic nxt_cpu_init;
  logic nxt_pos_claim;
  logic nxt_sub_claim;

  // ==========================================
  // Shared helpers
  // Native function when its select is set, otherwise the plain output value
  function automatic logic pin_source(input logic sel, input logic native, input logic plain);
    pin_source = sel ? native : plain;
  endfunction
  // Newer processors take reset and init active low, so the strap flips the level
  function automatic logic cpu_polarity(input logic active, input logic newer);
    cpu_polarity = active ^ newer;
  endfunction

  // ==========================================
  // Power-good crossing
  gmrs_sync u_pg_sync (
    .clk(REF_CLK),
    .din(POWER_GOOD),
    .dout(pg_sync)
  );

  // Power-good low resets the whole core plane, same as the system reset
  assign core_rst = SYS_RST | ~pg_sync;

  // ==========================================
  // Reset sequencing
  always_comb begin
    case (state_ff)
      gmrs_pkg::GMRS_IN_RESET: nxt_state = pg_sync ? gmrs_pkg::GMRS_RUN : gmrs_pkg::GMRS_IN_RESET;
      gmrs_pkg::GMRS_RUN: nxt_state = pg_sync ? gmrs_pkg::GMRS_RUN : gmrs_pkg::GMRS_IN_RESET;
      default: nxt_state = gmrs_pkg::GMRS_IN_RESET;
    endcase
  end
  assign in_reset = SYS_RST | (nxt_state == gmrs_pkg::GMRS_IN_RESET);

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_ff <= gmrs_pkg::GMRS_IN_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge REF_CLK) begin
    if (core_rst) begin
      general_config_reg_ff <= `GMRS_GCFG_RST;
      xbus_control_reg_ff <= `GMRS_XBUS_RST;
      gpo_ff <= `GMRS_GPO_RST;
      speaker_out_en_ff <= 1'b0;
    end else begin
      if (GENERAL_CONFIG_WE) begin
        general_config_reg_ff <= GENERAL_CONFIG_WDATA;
      end
      if (XBUS_CONTROL_WE) begin
        xbus_control_reg_ff <= XBUS_CONTROL_WDATA;
      end
      if (GENERAL_OUT_WE) begin
        gpo_ff <= GENERAL_OUT_WDATA;
      end
      if (PORT61_WE) begin
        speaker_out_en_ff <= PORT61_WDATA[`GMRS_SPEAKER_OUT_EN_BIT];
      end
    end
  end

  // ==========================================
  // Straps: caught while in reset, frozen afterwards since the board keeps them static
  always_ff @(posedge REF_CLK) begin
    if (in_reset) begin
      cpu_type_ff <= CPU_TYPE_STRAP;
      boot_decode_ff <= BOOT_DECODE_STRAP;
    end
  end

  // ==========================================
  // Pin mux; the output register adds one cycle so pins come from flops
  assign sel_clk_cs = general_config_reg_ff[`GMRS_GCFG_CLK_CS_BIT];
  assign sel_clk_ale = general_config_reg_ff[`GMRS_GCFG_CLK_ALE_BIT];
  assign sel_kbc_cs = general_config_reg_ff[`GMRS_GCFG_KBC_CS_BIT];
  assign sel_apic = xbus_control_reg_ff[`GMRS_XBUS_APIC_BIT];
  assign nxt_pin[0] = pin_source(sel_clk_cs, NATIVE_IN.clock_chip_select_n,
    gpo_ff[0]);
  assign nxt_pin[1] = pin_source(sel_clk_ale, NATIVE_IN.clock_chip_addr_latch,
    gpo_ff[1]);
  assign nxt_pin[2] = pin_source(sel_kbc_cs, NATIVE_IN.keyboard_ctrl_select_n,
    gpo_ff[2]);
  assign nxt_pin[4:3] = gpo_ff[4:3];
  assign nxt_pin[5] = pin_source(sel_apic, NATIVE_IN.apic_int9_out_n, gpo_ff[5]);
  assign nxt_pin[6] = gpo_ff[6];

  // Speaker freezes during power-on-suspend
  assign nxt_speaker_out = POWER_ON_SUSPEND ? speaker_out_ff : (COUNTER2_OUT & speaker_out_en_ff);

  always_ff @(posedge REF_CLK) begin
    if (core_rst) begin
      pin_ff <= `GMRS_GPO_RST;
      speaker_out_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
      speaker_out_ff <= nxt_speaker_out;
    end
  end

  // ==========================================
  // Reset and init outputs; newer processors take active-low reset and init
  assign nxt_cpu_rst = cpu_polarity(in_reset, cpu_type_ff);
  assign nxt_cpu_init = cpu_polarity(CPU_INIT_REQ & ~in_reset, cpu_type_ff);
  always_ff @(posedge REF_CLK) begin
    cpu_rst_ff <= nxt_cpu_rst;
    cpu_init_ff <= nxt_cpu_init;
    pci_rst_n_ff <= ~in_reset;
    isa_rst_ff <= in_reset;
  end

  // ==========================================
  // Top 64K decode; the frozen strap copy keeps a board glitch from flipping the claim
  assign nxt_pos_claim = TOP64K_HIT & ~boot_decode_ff;
  assign nxt_sub_claim = TOP64K_HIT & boot_decode_ff;
  always_ff @(posedge REF_CLK) begin
    if (core_rst) begin
      pos_claim_ff <= 1'b0;
      sub_claim_ff <= 1'b0;
    end else begin
      pos_claim_ff <= nxt_pos_claim;
      sub_claim_ff <= nxt_sub_claim;
    end
  end

  assign GENERAL_OUT_24 = pin_ff[0];
  assign GENERAL_OUT_25 = pin_ff[1];
  assign GENERAL_OUT_26 = pin_ff[2];
  assign GENERAL_OUT_27_28 = pin_ff[4:3];
  assign GENERAL_OUT_29 = pin_ff[5];
  assign GENERAL_OUT_30 = pin_ff[6];
  assign CPU_RESET_OUT = cpu_rst_ff;
  assign CPU_INIT_OUT = cpu_init_ff;
  assign PCI_RESET_OUT_N = pci_rst_n_ff;
  assign ISA_RESET_DRIVE = isa_rst_ff;
  assign SPEAKER_OUT = speaker_out_ff;
  assign TOP64K_POSITIVE_CLAIM = pos_claim_ff;
  assign TOP64K_SUBTRACTIVE_CLAIM = sub_claim_ff;
  assign GENERAL_CONFIG_RDATA = general_config_reg_ff;
  assign XBUS_CONTROL_RDATA = xbus_control_reg_ff;
endmodule

// [test/gmrs_partner.sv]
// Far-side model of clock chip, keyboard controller and APIC select lines
`timescale 1ns/1ps
module gmrs_partner (
  input wire logic clk,
  output gmrs_pkg::gmrs_native_t nat
);
  // Pattern changes every cycle so a pin stuck on the wrong source shows up
  logic [3:0] cnt_ff = 4'h0;
  always_ff @(posedge clk) begin
    cnt_ff <= cnt_ff + 4'h1;
  end
  assign nat = gmrs_pkg::gmrs_native_t'(cnt_ff);
endmodule

// [test/gmrs_checker.sv]
// Assertions on the pin mux, reset outputs and speaker
`timescale 1ns/1ps
module gmrs_checker (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic POWER_GOOD,
  input wire logic POWER_ON_SUSPEND,
  input wire gmrs_pkg::gmrs_native_t NATIVE_IN,
  input wire logic [31:0] GENERAL_CONFIG_RDATA,
  input wire logic [15:0] XBUS_CONTROL_RDATA,
  input wire logic GENERAL_OUT_24,
  input wire logic GENERAL_OUT_25,
  input wire logic GENERAL_OUT_26,
  input wire logic GENERAL_OUT_29,
  input wire logic PCI_RESET_OUT_N,
  input wire logic ISA_RESET_DRIVE,
  input wire logic SPEAKER_OUT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // ==========================================
  // Run qualifier: power good long enough for the synchroniser to settle
  logic [3:0] run_ff;
  logic [3:0] nxt_run;
  assign nxt_run = !POWER_GOOD ? 4'h0 : run_ff + {3'h0, run_ff != 4'hf};
  always_ff @(posedge REF_CLK) begin
    run_ff <= SYS_RST ? 4'h0 : nxt_run;
  end
  sequence pg_low_s;
    !POWER_GOOD [*6];
  endsequence
  sequence pg_rise_s;
    !POWER_GOOD [*6] ##1 POWER_GOOD [*2];
  endsequence
  // ==========================================
  // Assertions
  AST_CLK_CS: assert property (run_ff[3] && $past(GENERAL_CONFIG_RDATA[29]) |->
    GENERAL_OUT_24 == $past(NATIVE_IN.clock_chip_select_n)) else $error("pin 24 source");
  AST_CLK_ALE: assert property (run_ff[3] && $past(GENERAL_CONFIG_RDATA[30]) |->
    GENERAL_OUT_25 == $past(NATIVE_IN.clock_chip_addr_latch)) else $error("pin 25 source");
  AST_KBC_CS: assert property (run_ff[3] && $past(GENERAL_CONFIG_RDATA[31]) |->
    GENERAL_OUT_26 == $past(NATIVE_IN.keyboard_ctrl_select_n)) else $error("pin 26 source");
  AST_APIC_INT: assert property (run_ff[3] && $past(XBUS_CONTROL_RDATA[8]) |->
    GENERAL_OUT_29 == $past(NATIVE_IN.apic_int9_out_n)) else $error("pin 29 source");
  AST_PG_LOW: assert property (pg_low_s |-> !PCI_RESET_OUT_N && ISA_RESET_DRIVE)
    else $error("resets not asserted");
  AST_PG_SYNC: assert property (pg_rise_s |-> !PCI_RESET_OUT_N && ISA_RESET_DRIVE)
    else $error("release before sync");
  AST_PG_REL: assert property (run_ff[3] |-> PCI_RESET_OUT_N && !ISA_RESET_DRIVE)
    else $error("resets not released");
  AST_SPK_HOLD: assert property (run_ff[3] && $past(POWER_ON_SUSPEND) |->
    $stable(SPEAKER_OUT)) else $error("speaker moved in suspend");
  AST_SPK_RST: assert property ($fell(SYS_RST) |-> !SPEAKER_OUT)
    else $error("speaker high in reset");
endmodule
bind gmrs_top gmrs_checker u_gmrs_checker (.*);

// [test/tb.sv]
// Self-checking bench for the output mux, strap, reset and speaker glue
`timescale 1ns/1ps
module tb;
  logic REF_CLK = 1'b0, SYS_RST = 1'b1, POWER_GOOD = 1'b0, CPU_TYPE_STRAP = 1'b0;
  logic BOOT_DECODE_STRAP = 1'b0, GENERAL_CONFIG_WE = 1'b0, XBUS_CONTROL_WE = 1'b0;
  logic GENERAL_OUT_WE = 1'b0, PORT61_WE = 1'b0, CPU_INIT_REQ = 1'b0, COUNTER2_OUT = 1'b0;
  logic POWER_ON_SUSPEND = 1'b0, TOP64K_HIT = 1'b0, GENERAL_OUT_24, GENERAL_OUT_25;
  logic GENERAL_OUT_26, GENERAL_OUT_29, GENERAL_OUT_30, CPU_RESET_OUT, CPU_INIT_OUT;
  logic PCI_RESET_OUT_N, ISA_RESET_DRIVE, SPEAKER_OUT, TOP64K_POSITIVE_CLAIM;
  logic TOP64K_SUBTRACTIVE_CLAIM;
  logic [31:0] GENERAL_CONFIG_WDATA = 32'h0, GENERAL_CONFIG_RDATA;
  logic [15:0] XBUS_CONTROL_WDATA = 16'h0, XBUS_CONTROL_RDATA;
  logic [6:0] GENERAL_OUT_WDATA = 7'h0;
  logic [7:0] PORT61_WDATA = 8'h0;
  logic [1:0] GENERAL_OUT_27_28;
  gmrs_pkg::gmrs_native_t NATIVE_IN;
  int err_count = 0, compares = 0;
  always #5 REF_CLK = ~REF_CLK;
  gmrs_top u_gmrs_top (.*);
  gmrs_partner u_gmrs_partner (.clk(REF_CLK), .nat(NATIVE_IN));
  // ==========================================
  // Tasks
  task cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  // One write cycle; we bits are {config, xbus, outputs, port61}
  task wr(input logic [3:0] we, input logic [31:0] d);
    @(posedge REF_CLK);
    {GENERAL_CONFIG_WE, XBUS_CONTROL_WE, GENERAL_OUT_WE, PORT61_WE} <= we;
    GENERAL_CONFIG_WDATA <= d;
    XBUS_CONTROL_WDATA <= d[15:0];
    GENERAL_OUT_WDATA <= d[6:0];
    PORT61_WDATA <= d[7:0];
    @(posedge REF_CLK);
    {GENERAL_CONFIG_WE, XBUS_CONTROL_WE, GENERAL_OUT_WE, PORT61_WE} <= 4'h0;
  endtask
  // Value is copied in when called, at the edge; the 1 ns wait only delays the compare
  task chk(input logic [31:0] g, input logic [31:0] e);
    #1;
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task final_report;
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    cyc(10);
    SYS_RST <= 1'b0;
    POWER_GOOD <= 1'b1;
    cyc(6);
    chk(GENERAL_CONFIG_RDATA, 32'he0000000);
    wr(4'h2, 32'h7f);
    wr(4'h8, 32'h0);
    cyc(3);
    chk({GENERAL_OUT_24, GENERAL_OUT_25, GENERAL_OUT_26, GENERAL_OUT_27_28,
      GENERAL_OUT_29, GENERAL_OUT_30}, 32'h7f);
    wr(4'h4, 32'h0100);
    cyc(3);
    chk({XBUS_CONTROL_RDATA, 15'h0, GENERAL_OUT_30}, 32'h01000001);
    @(posedge REF_CLK);
    COUNTER2_OUT <= 1'b1;
    wr(4'h1, 32'h02);
    cyc(2);
    chk(SPEAKER_OUT, 32'h1);
    @(posedge REF_CLK);
    POWER_ON_SUSPEND <= 1'b1;
    COUNTER2_OUT <= 1'b0;
    cyc(3);
    chk(SPEAKER_OUT, 32'h1);
    @(posedge REF_CLK);
    POWER_ON_SUSPEND <= 1'b0;
    TOP64K_HIT <= 1'b1;
    CPU_INIT_REQ <= 1'b1;
    cyc(2);
    chk({SPEAKER_OUT, TOP64K_POSITIVE_CLAIM, TOP64K_SUBTRACTIVE_CLAIM, CPU_INIT_OUT},
      32'h5);
    @(posedge REF_CLK);
    TOP64K_HIT <= 1'b0;
    POWER_GOOD <= 1'b0;
    CPU_TYPE_STRAP <= 1'b1;
    // Strap moves only while power is bad, never during operation
    BOOT_DECODE_STRAP <= 1'b1;
    cyc(8);
    chk({CPU_RESET_OUT, PCI_RESET_OUT_N, ISA_RESET_DRIVE, CPU_INIT_OUT},
      32'h3);
    chk(GENERAL_CONFIG_RDATA, 32'he0000000);
    @(posedge REF_CLK);
    POWER_GOOD <= 1'b1;
    cyc(6);
    chk({CPU_RESET_OUT, PCI_RESET_OUT_N, ISA_RESET_DRIVE, CPU_INIT_OUT},
      32'hc);
    @(posedge REF_CLK);
    TOP64K_HIT <= 1'b1;
    cyc(2);
    chk({TOP64K_POSITIVE_CLAIM, TOP64K_SUBTRACTIVE_CLAIM}, 32'h1);
    final_report;
  end
  // Whole sequence is well under 200 cycles
  initial begin
    #20000;
    err_count++;
    final_report;
  end
endmodule
